// ---- tmoc_pkg.sv ----
package tmoc_pkg;

    // register offsets, word addressed on the avalon bus
    localparam logic [2:0] REG_CONTROL  = 3'h0;
    localparam logic [2:0] REG_COUNTER  = 3'h1;
    localparam logic [2:0] REG_COMPARE  = 3'h2;
    localparam logic [2:0] REG_FLAGS    = 3'h3;
    localparam logic [2:0] REG_IRQ_EN   = 3'h4;
    localparam logic [2:0] REG_PIN      = 3'h5;
    localparam logic [2:0] REG_IRQ_ACK  = 3'h6;

    // control register fields
    localparam int CTL_WAVE_LSB   = 0;
    localparam int CTL_ACTION_LSB = 2;
    localparam int CTL_FORCE_BIT  = 4;
    localparam int CTL_RUN_BIT    = 5;

    // flag and enable fields
    localparam int FLG_OVF_BIT    = 0;
    localparam int FLG_CMP_BIT    = 1;

    // pin register fields
    localparam int PIN_PORT_BIT   = 0;
    localparam int PIN_DIR_BIT    = 1;

    localparam logic [7:0] CNT_BOTTOM  = 8'h00;
    localparam logic [7:0] CNT_MAX     = 8'hFF;
    localparam logic [7:0] RESET_VALUE = 8'h00;

    localparam logic [1:0] WAVE_NORMAL  = 2'h0;
    localparam logic [1:0] WAVE_PHASE   = 2'h1;
    localparam logic [1:0] WAVE_CLEAR   = 2'h2;
    localparam logic [1:0] WAVE_FAST    = 2'h3;

    localparam logic [1:0] ACT_NONE     = 2'h0;
    localparam logic [1:0] ACT_TOGGLE   = 2'h1;
    localparam logic [1:0] ACT_CLEAR    = 2'h2;
    localparam logic [1:0] ACT_SET      = 2'h3;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_ANSWER
    } tmoc_bus_type;

    typedef struct packed {
        logic [2:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } tmoc_req_type;

    typedef struct packed {
        tmoc_bus_type bus;
        logic [31:0]  readdata;
        logic [7:0]   counter_value;
        logic [7:0]   compare_value;
        logic [7:0]   compare_buffer;
        logic [1:0]   waveform_select;
        logic [1:0]   output_action;
        logic         timer_run;
        logic         count_down;
        logic         match_pending;
        logic         block_match;
        logic         compare_flag;
        logic         overflow_flag;
        logic         compare_irq_enable;
        logic         overflow_irq_enable;
        logic         wave_output;
        logic         port_value;
        logic         wave_pin_direction_bit;
        logic         pin_out;
        logic         pin_oe_n;
        logic         irq_compare;
        logic         irq_overflow;
    } tmoc_state_type;

endpackage : tmoc_pkg

// ---- tmoc_timer.sv ----
`timescale 1ns/1ps
// Function
// - compare counter with compare value continuously
// - compare flag set one cycle after match
// - enabled flag requests irq, acknowledge clears
// - writing one clears flag, zero ignored
// - pwm modes buffer compare, others direct
// - buffer copied only at top or bottom
// - compare writes reach buffer when buffering
// - force strobe acts as match, non-pwm
// - counter write blocks next cycle's match
// - output action takes effect at once
// - wave output kept across mode changes
// - nonzero action overrides port pin value
// - action zero leaves wave output alone
// - counting independent of output action
// - normal mode counts up, wraps
// - overflow flag set as counter hits zero, except clear on match below ff
// - overflow flag cleared on irq service
// - normal mode accepts counter writes anytime
// - bottom zero, max ff, top per mode
// - counter write beats clear or count
// - selection two is clear on match
// - three fast pwm, one phase correct
module tmoc_timer
    import tmoc_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // timer clock enable from prescaler, same clock domain
    input  wire logic        timer_tick,
    // interrupt service acknowledges
    input  wire logic        ack_compare,
    input  wire logic        ack_overflow,
    // avalon-mm slave
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // wave pin
    output logic             wave_pin_out,
    output logic             wave_pin_oe_n,
    // interrupt requests
    output logic             irq_compare,
    output logic             irq_overflow
);

    tmoc_state_type s_q;
    tmoc_state_type s_d;
    tmoc_req_type   req;

    function automatic logic is_pwm(input logic [1:0] mode);
        return (mode == WAVE_FAST) || (mode == WAVE_PHASE);
    endfunction : is_pwm

    function automatic logic next_wave(input logic [1:0] act, input logic cur, input logic up_or_set);
        logic r;
        r = cur;
        case (act)
            ACT_NONE:   r = cur;
            ACT_TOGGLE: r = ~cur;
            ACT_CLEAR:  r = ~up_or_set;
            ACT_SET:    r = up_or_set;
            default:    r = cur;
        endcase
        return r;
    endfunction : next_wave

    logic       bus_wr;
    logic       bus_rd;
    logic       wr_counter;
    logic       match;
    logic       run_tick;
    logic [7:0] top_value;

    assign req.address   = avs_address;
    assign req.read      = avs_read;
    assign req.write     = avs_write;
    assign req.writedata = avs_writedata;

    assign bus_wr     = req.write && (s_q.bus == BUS_IDLE) && avs_byteenable[0];
    assign bus_rd     = req.read && (s_q.bus == BUS_IDLE);
    assign wr_counter = bus_wr && (req.address == REG_COUNTER);
    assign run_tick   = timer_tick && s_q.timer_run;
    assign match      = (s_q.counter_value == s_q.compare_value) && !s_q.block_match;
    assign top_value  = (s_q.waveform_select == WAVE_CLEAR) ? s_q.compare_value : CNT_MAX;

    always_comb begin
        logic       pwm;
        logic       at_bottom;
        logic       at_top;
        logic [7:0] wdat;
        pwm       = is_pwm(s_q.waveform_select);
        at_bottom = 1'b0;
        at_top    = 1'b0;
        wdat      = req.writedata[7:0];
        s_d       = s_q;

        // bus answer: one wait cycle, readdata from register
        case (s_q.bus)
            BUS_IDLE: begin
                if (req.read || req.write) begin
                    s_d.bus = BUS_ANSWER;
                end
            end
            BUS_ANSWER: s_d.bus = BUS_IDLE;
            default:    s_d.bus = BUS_IDLE;
        endcase

        // counter sequence depends on waveform select, and in clear on match also on the compare value as top
        if (run_tick) begin
            case (s_q.waveform_select)
                WAVE_NORMAL: begin
                    s_d.counter_value = s_q.counter_value + 8'h01;
                    at_bottom = (s_q.counter_value == CNT_MAX);
                end
                WAVE_CLEAR: begin
                    if (s_q.counter_value == top_value) begin
                        s_d.counter_value = CNT_BOTTOM;
                    end else begin
                        s_d.counter_value = s_q.counter_value + 8'h01;
                    end
                    at_bottom = (s_q.counter_value == CNT_MAX);
                end
                WAVE_FAST: begin
                    s_d.counter_value = s_q.counter_value + 8'h01;
                    at_bottom = (s_q.counter_value == CNT_MAX);
                    at_top    = at_bottom;
                end
                WAVE_PHASE: begin
                    if (s_q.count_down) begin
                        s_d.counter_value = s_q.counter_value - 8'h01;
                        if (s_q.counter_value == 8'h01) begin
                            s_d.count_down = 1'b0;
                            at_bottom = 1'b1;
                        end
                    end else begin
                        s_d.counter_value = s_q.counter_value + 8'h01;
                        if (s_q.counter_value == 8'hFE) begin
                            s_d.count_down = 1'b1;
                            at_top = 1'b1;
                        end
                    end
                end
                default: s_d.counter_value = s_q.counter_value;
            endcase
            if (at_bottom) begin
                s_d.overflow_flag = 1'b1;
            end
            if (pwm && (at_top || at_bottom)) begin
                s_d.compare_value = s_q.compare_buffer;
            end
            // fast pwm: restore at bottom
            if ((s_q.waveform_select == WAVE_FAST) && at_bottom && s_q.output_action[1]) begin
                s_d.wave_output = next_wave(s_q.output_action, s_q.wave_output, 1'b0);
            end
        end

        // match: waveform and flag on the following timer cycle
        s_d.match_pending = s_q.match_pending;
        if (run_tick) begin
            s_d.match_pending = match;
            if (match) begin
                s_d.compare_flag = 1'b1;
            end
            if (match) begin
                if (s_q.waveform_select == WAVE_PHASE) begin
                    s_d.wave_output = next_wave(s_q.output_action, s_q.wave_output, ~s_q.count_down);
                end else if (s_q.waveform_select == WAVE_FAST) begin
                    s_d.wave_output = next_wave(s_q.output_action, s_q.wave_output, 1'b1);
                end else begin
                    s_d.wave_output = next_wave(s_q.output_action, s_q.wave_output, 1'b1);
                end
            end
            s_d.block_match = 1'b0;
        end
        if (!pwm && bus_wr && (req.address == REG_CONTROL) && req.writedata[CTL_FORCE_BIT]) begin
            s_d.wave_output = next_wave(req.writedata[CTL_ACTION_LSB +: 2], s_q.wave_output, 1'b1);
        end

        // software writes
        if (bus_wr) begin
            case (req.address)
                REG_CONTROL: begin
                    s_d.waveform_select = req.writedata[CTL_WAVE_LSB +: 2];
                    s_d.output_action   = req.writedata[CTL_ACTION_LSB +: 2];
                    s_d.timer_run       = req.writedata[CTL_RUN_BIT];
                end
                REG_COUNTER: begin
                    s_d.counter_value = wdat;
                    s_d.block_match   = 1'b1;
                    s_d.match_pending = 1'b0;
                end
                REG_COMPARE: begin
                    if (pwm) begin
                        s_d.compare_buffer = wdat;
                    end else begin
                        s_d.compare_value  = wdat;
                        s_d.compare_buffer = wdat;
                    end
                end
                REG_IRQ_EN: begin
                    s_d.overflow_irq_enable = req.writedata[FLG_OVF_BIT];
                    s_d.compare_irq_enable  = req.writedata[FLG_CMP_BIT];
                end
                REG_PIN: begin
                    s_d.port_value             = req.writedata[PIN_PORT_BIT];
                    s_d.wave_pin_direction_bit = req.writedata[PIN_DIR_BIT];
                end
                default: s_d.counter_value = s_d.counter_value;
            endcase
        end
        // clears: a same-cycle hardware set wins
        if (bus_wr && (req.address == REG_FLAGS)) begin
            if (req.writedata[FLG_CMP_BIT] && !(run_tick && match)) begin
                s_d.compare_flag = 1'b0;
            end
            if (req.writedata[FLG_OVF_BIT] && !(run_tick && at_bottom)) begin
                s_d.overflow_flag = 1'b0;
            end
        end
        if (ack_compare && s_q.irq_compare && !(run_tick && match)) begin
            s_d.compare_flag = 1'b0;
        end
        if (ack_overflow && s_q.irq_overflow && !(run_tick && at_bottom)) begin
            s_d.overflow_flag = 1'b0;
        end

        s_d.irq_compare  = s_d.compare_flag && s_d.compare_irq_enable;
        s_d.irq_overflow = s_d.overflow_flag && s_d.overflow_irq_enable;
        s_d.pin_out      = (s_d.output_action != ACT_NONE) ? s_d.wave_output : s_d.port_value;
        s_d.pin_oe_n     = ~s_d.wave_pin_direction_bit;

        s_d.readdata = 32'h0000_0000;
        if (bus_rd) begin
            case (req.address)
                REG_CONTROL: begin
                    s_d.readdata[CTL_WAVE_LSB +: 2]   = s_q.waveform_select;
                    s_d.readdata[CTL_ACTION_LSB +: 2] = s_q.output_action;
                    s_d.readdata[CTL_RUN_BIT]         = s_q.timer_run;
                end
                REG_COUNTER: s_d.readdata[7:0] = s_q.counter_value;
                REG_COMPARE: s_d.readdata[7:0] = pwm ? s_q.compare_buffer : s_q.compare_value;
                REG_FLAGS: begin
                    s_d.readdata[FLG_OVF_BIT] = s_q.overflow_flag;
                    s_d.readdata[FLG_CMP_BIT] = s_q.compare_flag;
                end
                REG_IRQ_EN: begin
                    s_d.readdata[FLG_OVF_BIT] = s_q.overflow_irq_enable;
                    s_d.readdata[FLG_CMP_BIT] = s_q.compare_irq_enable;
                end
                REG_PIN: begin
                    s_d.readdata[PIN_PORT_BIT] = s_q.port_value;
                    s_d.readdata[PIN_DIR_BIT]  = s_q.wave_pin_direction_bit;
                end
                default: s_d.readdata = 32'h0000_0000;
            endcase
        end else if (s_q.bus == BUS_ANSWER) begin
            s_d.readdata = s_q.readdata;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_q          <= '0;
            s_q.bus      <= BUS_IDLE;
            s_q.pin_oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata    = s_q.readdata;
    assign avs_waitrequest = (s_q.bus == BUS_IDLE);
    assign wave_pin_out    = s_q.pin_out;
    assign wave_pin_oe_n   = s_q.pin_oe_n;
    assign irq_compare     = s_q.irq_compare;
    assign irq_overflow    = s_q.irq_overflow;

    sequence s_phase_match_up;
        run_tick && match && (s_q.waveform_select == WAVE_PHASE) && !s_q.count_down;
    endsequence

    sequence s_phase_match_down;
        run_tick && match && (s_q.waveform_select == WAVE_PHASE) && s_q.count_down;
    endsequence

    a_flag_after_match: assert property (@(posedge clk) disable iff (reset)
        (run_tick && match && !wr_counter) |=> s_q.compare_flag && s_q.match_pending)
        else $error("compare flag not set after match");

    a_block_after_write: assert property (@(posedge clk) disable iff (reset)
        wr_counter |=> !match)
        else $error("match not blocked after counter write");

    a_normal_wrap: assert property (@(posedge clk) disable iff (reset)
        (run_tick && !bus_wr && s_q.waveform_select == WAVE_NORMAL && s_q.counter_value == CNT_MAX)
        |=> (s_q.counter_value == CNT_BOTTOM) && s_q.overflow_flag)
        else $error("normal wrap or overflow flag wrong");

    a_counter_write_wins: assert property (@(posedge clk) disable iff (reset)
        wr_counter |=> s_q.counter_value == $past(avs_writedata[7:0]))
        else $error("counter write lost");

    a_direct_compare: assert property (@(posedge clk) disable iff (reset)
        (bus_wr && req.address == REG_COMPARE && !is_pwm(s_q.waveform_select))
        |=> s_q.compare_value == $past(avs_writedata[7:0]))
        else $error("non-buffered compare write not direct");

    a_buffered_hold: assert property (@(posedge clk) disable iff (reset)
        (is_pwm(s_q.waveform_select) && !run_tick && !bus_wr) |=> $stable(s_q.compare_value))
        else $error("buffered compare changed off top and bottom");

    a_action_none: assert property (@(posedge clk) disable iff (reset)
        (s_q.output_action == ACT_NONE && !bus_wr) |=> $stable(s_q.wave_output))
        else $error("wave output changed with no action");

    a_force_no_flag: assert property (@(posedge clk) disable iff (reset)
        (bus_wr && req.address == REG_CONTROL && !run_tick && !s_q.compare_flag
        && !(ack_compare)) |=> !s_q.compare_flag)
        else $error("force set compare flag");

    a_irq_follows: assert property (@(posedge clk) disable iff (reset)
        irq_compare == (s_q.compare_flag && s_q.compare_irq_enable))
        else $error("compare irq mismatch");

    a_pin_override: assert property (@(posedge clk) disable iff (reset)
        (s_q.output_action != ACT_NONE) |-> wave_pin_out == s_q.wave_output)
        else $error("pin not driven from wave output");

    a_pin_direction: assert property (@(posedge clk) disable iff (reset)
        wave_pin_oe_n == !s_q.wave_pin_direction_bit)
        else $error("pin direction not from direction bit");

    a_cmp_ack_clear: assert property (@(posedge clk) disable iff (reset)
        (ack_compare && irq_compare && !run_tick) |=> !s_q.compare_flag)
        else $error("compare flag kept after service");

    a_ovf_ack_clear: assert property (@(posedge clk) disable iff (reset)
        (ack_overflow && irq_overflow && !run_tick) |=> !s_q.overflow_flag)
        else $error("overflow flag kept after service");

    a_flag_write_clear: assert property (@(posedge clk) disable iff (reset)
        (bus_wr && req.address == REG_FLAGS && req.writedata[FLG_CMP_BIT] && !run_tick) |=> !s_q.compare_flag)
        else $error("compare flag kept after write of one");

    a_flag_zero_keep: assert property (@(posedge clk) disable iff (reset)
        (bus_wr && req.address == REG_FLAGS && !req.writedata[FLG_CMP_BIT] && s_q.compare_flag && !ack_compare)
        |=> s_q.compare_flag)
        else $error("compare flag lost on write of zero");

    a_overflow_kept: assert property (@(posedge clk) disable iff (reset)
        (s_q.overflow_flag && !ack_overflow && !bus_wr) |=> s_q.overflow_flag)
        else $error("overflow flag cleared by hardware");

    a_stopped_hold: assert property (@(posedge clk) disable iff (reset)
        (!s_q.timer_run && !bus_wr) |=> $stable(s_q.counter_value))
        else $error("stopped counter moved");

    a_mode_keeps_wave: assert property (@(posedge clk) disable iff (reset)
        (bus_wr && req.address == REG_CONTROL && !req.writedata[CTL_FORCE_BIT] && !run_tick)
        |=> $stable(s_q.wave_output))
        else $error("wave output changed with mode write");

    a_force_pwm_none: assert property (@(posedge clk) disable iff (reset)
        (bus_wr && req.address == REG_CONTROL && is_pwm(s_q.waveform_select) && !run_tick)
        |=> $stable(s_q.wave_output))
        else $error("force acted in pwm mode");

    a_ctc_clear: assert property (@(posedge clk) disable iff (reset)
        (run_tick && !bus_wr && s_q.waveform_select == WAVE_CLEAR && s_q.counter_value == s_q.compare_value)
        |=> s_q.counter_value == CNT_BOTTOM)
        else $error("counter not cleared on match");

    a_phase_up_clear: assert property (@(posedge clk) disable iff (reset)
        s_phase_match_up ##0 (s_q.output_action == ACT_CLEAR) |=> !s_q.wave_output)
        else $error("phase up match did not clear wave output");

    a_phase_down_set: assert property (@(posedge clk) disable iff (reset)
        s_phase_match_down ##0 (s_q.output_action == ACT_CLEAR) |=> s_q.wave_output)
        else $error("phase down match did not set wave output");

endmodule : tmoc_timer

// ---- tmoc_cpu_model.sv ----
`timescale 1ns/1ps
module tmoc_cpu_model
    import tmoc_pkg::*;
(
    // clock
    input  wire logic        clk,
    // avalon-mm master
    output logic      [2:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    initial begin
        avs_address    = 3'h0;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'h0;
    end

    // held until waitrequest sampled low; stale data scrambled after release
    task automatic access(input logic [2:0] a, input logic w, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] q);
        @(posedge clk);
        avs_address    <= a;
        avs_read       <= ~w;
        avs_write      <= w;
        avs_writedata  <= d;
        avs_byteenable <= be;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        q = avs_readdata;
        avs_read       <= 1'b0;
        avs_write      <= 1'b0;
        avs_address    <= ~a;
        avs_writedata  <= ~d;
        avs_byteenable <= ~be;
    endtask : access
endmodule : tmoc_cpu_model

// ---- tmoc_timer_tb_top.sv ----
`timescale 1ns/1ps
module tmoc_timer_tb_top;
    import tmoc_pkg::*;

    logic        clk = 1'b0;
    logic        reset;
    logic        timer_tick;
    logic        ack_compare;
    logic        ack_overflow;
    logic [2:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        wave_pin_out;
    logic        wave_pin_oe_n;
    logic        irq_compare;
    logic        irq_overflow;
    int          n_errors = 0;
    int          n_tests = 0;
    int          cycles = 0;
    logic [31:0] q;
    logic [7:0]  cv;
    logic [7:0]  bv;
    logic [1:0]  act;
    logic        wave = 1'b0;
    localparam logic [31:0] RUN = 32'h1 << CTL_RUN_BIT;
    localparam logic [31:0] FRC = 32'h1 << CTL_FORCE_BIT;
    localparam logic [31:0] TGL = 32'(ACT_TOGGLE) << CTL_ACTION_LSB;

    tmoc_timer i_dut (
        .clk, .reset, .timer_tick, .ack_compare, .ack_overflow,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .wave_pin_out, .wave_pin_oe_n,
        .irq_compare, .irq_overflow
    );
    tmoc_cpu_model i_cpu (
        .clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest
    );

    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end

    task automatic close_out;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [31:0] d);
        i_cpu.access(a, 1'b1, d, 4'hF, q);
    endtask : wr

    task automatic rdc(input logic [2:0] a, input logic [31:0] exp);
        i_cpu.access(a, 1'b0, 32'h0, 4'hF, q);
        chk(q, exp, "register read");
    endtask : rdc

    // {irq_overflow, irq_compare, wave_pin_oe_n, wave_pin_out}
    task automatic look(input logic [3:0] exp);
        repeat (2) @(posedge clk);
        chk({28'h0, irq_overflow, irq_compare, wave_pin_oe_n, wave_pin_out}, {28'h0, exp}, "outputs");
    endtask : look

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            timer_tick <= 1'b1;
            @(posedge clk);
            timer_tick <= 1'b0;
        end
    endtask : tick

    task automatic pulse_ack(input logic cmp);
        @(posedge clk);
        ack_compare  <= cmp;
        ack_overflow <= ~cmp;
        @(posedge clk);
        ack_compare  <= 1'b0;
        ack_overflow <= 1'b0;
    endtask : pulse_ack

    function automatic logic next_wave(logic w, logic [1:0] a);
        case (a)
            ACT_TOGGLE: return ~w;
            ACT_CLEAR:  return 1'b0;
            ACT_SET:    return 1'b1;
            default:    return w;
        endcase
    endfunction : next_wave

    initial begin
        reset        = 1'b1;
        timer_tick   = 1'b0;
        ack_compare  = 1'b0;
        ack_overflow = 1'b0;
        void'($urandom(35507));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        wr(REG_IRQ_ACK, 32'hFF);
        for (int a = 0; a < 7; a++) rdc(3'(a), 32'h0);
        look(4'b0010);
        // normal mode wrap and overflow
        wr(REG_COMPARE, 32'h80);
        wr(REG_CONTROL, RUN);
        wr(REG_COUNTER, 32'hFE);
        tick(1);
        rdc(REG_COUNTER, 32'hFF);
        tick(1);
        rdc(REG_COUNTER, 32'h00);
        rdc(REG_FLAGS, 32'h1);
        wr(REG_IRQ_EN, 32'h3);
        look(4'b1010);
        pulse_ack(1'b0);
        rdc(REG_FLAGS, 32'h0);
        // compare match, flag, interrupt
        cv = 8'($urandom_range(8'hE0, 8'h20));
        wr(REG_COMPARE, {24'h0, cv});
        wr(REG_COUNTER, {24'h0, cv - 8'h1});
        tick(1);
        rdc(REG_FLAGS, 32'h0);
        tick(2);
        rdc(REG_FLAGS, 32'h2);
        look(4'b0110);
        wr(REG_FLAGS, 32'h1);
        rdc(REG_FLAGS, 32'h2);
        pulse_ack(1'b1);
        rdc(REG_FLAGS, 32'h0);
        // counter write hides the match, partial write refused
        wr(REG_COUNTER, {24'h0, cv});
        tick(3);
        rdc(REG_FLAGS, 32'h0);
        i_cpu.access(REG_COUNTER, 1'b1, 32'h33, 4'hE, q);
        rdc(REG_COUNTER, {24'h0, cv + 8'h3});
        wr(REG_CONTROL, 32'h0);
        tick(2);
        rdc(REG_COUNTER, {24'h0, cv + 8'h3});
        // forced matches on a stopped timer, pin still an input
        for (int i = 0; i < 8; i++) begin
            act = (i < 4) ? 2'(i) : 2'($urandom_range(3, 0));
            wr(REG_CONTROL, FRC | (32'(act) << CTL_ACTION_LSB));
            wave = next_wave(wave, act);
            look({3'b001, (act != ACT_NONE) ? wave : 1'b0});
        end
        rdc(REG_FLAGS, 32'h0);
        rdc(REG_COUNTER, {24'h0, cv + 8'h3});
        rdc(REG_CONTROL, 32'(act) << CTL_ACTION_LSB);
        wr(REG_PIN, 32'h1 << PIN_DIR_BIT);
        for (int m = 0; m < 4; m++) begin
            wr(REG_CONTROL, 32'(m) | TGL);
            look({3'b000, wave});
        end
        wr(REG_CONTROL, FRC | TGL | 32'(WAVE_FAST));
        look({3'b000, wave});
        wr(REG_PIN, 32'h3);
        wr(REG_CONTROL, 32'(WAVE_FAST));
        look(4'b0001);
        // fast pwm: compare writes wait in the buffer until the wrap
        do bv = 8'($urandom_range(8'hE0, 8'h20)); while (bv - cv < 8'h8 || cv - bv < 8'h8);
        wr(REG_CONTROL, RUN | 32'(WAVE_FAST));
        wr(REG_COMPARE, {24'h0, bv});
        rdc(REG_COMPARE, {24'h0, bv});
        wr(REG_COUNTER, {24'h0, bv - 8'h1});
        tick(3);
        rdc(REG_FLAGS, 32'h0);
        wr(REG_COUNTER, 32'hFE);
        tick(3);
        wr(REG_COUNTER, {24'h0, bv - 8'h1});
        tick(3);
        rdc(REG_FLAGS, 32'h3);
        wr(REG_FLAGS, 32'h3);
        rdc(REG_FLAGS, 32'h0);
        // clear on match mode
        wr(REG_CONTROL, RUN | 32'(WAVE_CLEAR));
        wr(REG_COMPARE, {24'h0, cv});
        wr(REG_COUNTER, {24'h0, cv - 8'h1});
        tick(2);
        rdc(REG_COUNTER, 32'h0);
        // phase correct: clear on the way up, set on the way down
        wr(REG_CONTROL, RUN | 32'(WAVE_PHASE) | (32'(ACT_CLEAR) << CTL_ACTION_LSB));
        wr(REG_COUNTER, {24'h0, cv - 8'h1});
        tick(2);
        look(4'b0100);
        wr(REG_COUNTER, 32'hFD);
        tick(3);
        wr(REG_COUNTER, {24'h0, cv + 8'h1});
        tick(2);
        look(4'b0101);
        close_out();
    end
endmodule : tmoc_timer_tb_top
